// [logic/ppcs_pkg.sv]
/*
 pin configuration and strap package: register offsets, field positions,
 reset values, slave addresses and strap timing for the pin config block.
 assumes a 200 MHz core clock and a byte-addressed Avalon-MM slave.
*/
package ppcs_pkg;

   // ------------------------------------------------------------
   // register map (word indices, Avalon address bits 9:2)
   // ------------------------------------------------------------
   localparam logic [7:0] PPCS_IDX_EXP_CTRL   = 8'h83;
   localparam logic [7:0] PPCS_IDX_IMG_CTRL   = 8'h87;
   localparam logic [7:0] PPCS_IDX_EXP_FMT    = 8'h92;
   localparam logic [7:0] PPCS_IDX_STATUS     = 8'hA0;
   localparam int         PPCS_ADDR_W         = 10;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int         PPCS_ENF_LSB        = 0;
   localparam int         PPCS_VREF_LSB       = 4;
   localparam logic [1:0] PPCS_ENF_RST        = 2'h0;
   localparam logic [1:0] PPCS_VREF_RST       = 2'h0;
   localparam logic [7:0] PPCS_SLAVE_DEFAULT  = 8'h42;
   localparam logic [7:0] PPCS_SLAVE_ALT      = 8'h40;

   // vref field encodings
   localparam logic [1:0] PPCS_VREF_INPUT     = 2'h0;

   // port enable field encodings
   localparam logic [1:0] PPCS_EN_FLOAT       = 2'h0;
   localparam logic [1:0] PPCS_EN_DRIVE       = 2'h1;
   localparam logic [1:0] PPCS_EN_PIN_HI      = 2'h2;
   localparam logic [1:0] PPCS_EN_PIN_LO      = 2'h3;

   // ------------------------------------------------------------
   // strap sampling window
   // ------------------------------------------------------------
   localparam int         PPCS_STRAP_NS       = 1000;
   localparam int         PPCS_CLK_MHZ        = 200;
   localparam int         PPCS_STRAP_CYC      = (PPCS_STRAP_NS * PPCS_CLK_MHZ + 999) / 1000;
   localparam int         PPCS_CNT_W          = 8;

   typedef struct packed {
      logic realtime_ctrl_out_strap;
      logic audio_lr_clock_strap;
   } ppcs_strap_t;

   typedef struct packed {
      logic [1:0] exp_port_enable_field;
      logic [1:0] img_port_enable_field;
      logic [1:0] exp_vref_select_field;
   } ppcs_cfg_t;

endpackage

// [logic/ppcs_top.sv]
/*
 pin configuration and strap logic: strap capture after reset, port output
 enables, vertical reference pin control, test data output enable and the
 auxiliary oscillator output. registers over Avalon-MM with waitrequest.
 assumes pins are synchronised here; pad buffers live outside.
*/
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
// Contract
// - during power-up reset strap pins become inputs and are sampled
// - an unstrapped pin reads low via pull-down, giving the default
// - strap low gives slave address 42h/43h, high gives 40h/41h
// - audio clock strap low means 24.576 MHz crystal, high 32.110 MHz
// - test reset low forces tap to test-logic-reset at once (here tap_in_reset rises three edges late, after the synchroniser)
// - test data output driven only while the tap shifts data
// - vertical reference pin is input or output, chosen by 92h[5:4]
// - expansion port drivers follow 83h[1:0] with the external enable pin
// - image port drivers follow 87h[1:0] with the external enable pin
// - oscillator signal is driven on the auxiliary clock output
// - expansion enable pin use and polarity are set by software
`timescale 1ns/100ps
module ppcs_top (
   input  wire logic                          clk,
   input  wire logic                          reset,
   // avalon-mm slave
   input  wire logic [ppcs_pkg::PPCS_ADDR_W-1:0] avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic      [31:0]                   avs_readdata,
   output logic                               avs_waitrequest,
   // strap pins, three signals each
   input  wire logic                          realtime_ctrl_out_in,
   output logic                               realtime_ctrl_out_out,
   output logic                               realtime_ctrl_out_oe_n,
   input  wire logic                          audio_lr_clock_in,
   output logic                               audio_lr_clock_out,
   output logic                               audio_lr_clock_oe_n,
   input  wire logic                          rt_func_data,
   input  wire logic                          alr_func_data,
   // strap results
   output logic      [7:0]                    slave_address,
   output logic                               xtal_32m_sel,
   // port enables
   input  wire logic                          exp_port_output_enable_pin,
   input  wire logic                          img_port_output_enable_pin,
   output logic                               exp_port_oe_n,
   output logic                               img_port_oe_n,
   // expansion vertical reference pin
   input  wire logic                          exp_vertical_reference_in,
   input  wire logic                          dec_vref,
   output logic                               exp_vertical_reference_out,
   output logic                               exp_vertical_reference_oe_n,
   output logic                               exp_vref_captured,
   // boundary scan
   input  wire logic                          test_reset_n,
   input  wire logic                          tap_shift_dr,
   input  wire logic                          tap_shift_ir,
   input  wire logic                          tap_tdo_data,
   output logic                               tap_in_reset,
   output logic                               test_data_out,
   output logic                               test_data_out_oe_n,
   // oscillator
   input  wire logic                          osc_clk_div,
   output logic                               aux_oscillator_output
);

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [6:0] sync1_r;
   logic [6:0] sync2_r;
   logic [6:0] sync_nxt;
   always_comb begin
      sync_nxt = {realtime_ctrl_out_in,
                  audio_lr_clock_in,
                  exp_port_output_enable_pin,
                  img_port_output_enable_pin,
                  exp_vertical_reference_in,
                  test_reset_n,
                  osc_clk_div};
   end
   always_ff @(posedge clk) begin
      sync1_r <= sync_nxt;
      sync2_r <= sync1_r;
   end
   // only the second stage is read, so a metastable first stage never leaks
   logic rt_s;
   logic alr_s;
   logic xen_s;
   logic ien_s;
   logic vref_s;
   logic trst_n_s;
   logic osc_s;
   assign rt_s     = sync2_r[6];
   assign alr_s    = sync2_r[5];
   assign xen_s    = sync2_r[4];
   assign ien_s    = sync2_r[3];
   assign vref_s   = sync2_r[2];
   assign trst_n_s = sync2_r[1];
   assign osc_s    = sync2_r[0];

   // ------------------------------------------------------------
   // strap capture
   // ------------------------------------------------------------
   // counts out the window after reset so the pins settle through pull-downs
   // a pull-up fitted after the window is ignored until the next reset
   logic [ppcs_pkg::PPCS_CNT_W-1:0] cnt_r, cnt_nxt;
   logic                            sampling_r, sampling_nxt;
   ppcs_pkg::ppcs_strap_t           strap_r, strap_nxt;
   always_comb begin
      cnt_nxt      = cnt_r;
      sampling_nxt = sampling_r;
      strap_nxt    = strap_r;
      if (sampling_r) begin
         if (cnt_r == ppcs_pkg::PPCS_CNT_W'(ppcs_pkg::PPCS_STRAP_CYC)) begin
            strap_nxt.realtime_ctrl_out_strap = rt_s;
            strap_nxt.audio_lr_clock_strap    = alr_s;
            sampling_nxt = 1'b0;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_r      <= '0;
         sampling_r <= 1'b1;
         strap_r    <= '0;
      end else begin
         cnt_r      <= cnt_nxt;
         sampling_r <= sampling_nxt;
         strap_r    <= strap_nxt;
      end
   end

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   ppcs_pkg::ppcs_cfg_t cfg_r, cfg_nxt;
   logic                xen_use_r, xen_use_nxt;
   logic                xen_pol_r, xen_pol_nxt;
   logic [31:0]         rdata_r, rdata_nxt;
   logic                wait_r, wait_nxt;
   logic [7:0]          idx;
   logic                req;
   // unmapped words read as zero and swallow writes
   assign idx = avs_address[ppcs_pkg::PPCS_ADDR_W-1:2];
   assign req = avs_read | avs_write;

   always_comb begin
      cfg_nxt     = cfg_r;
      xen_use_nxt = xen_use_r;
      xen_pol_nxt = xen_pol_r;
      rdata_nxt   = rdata_r;
      wait_nxt    = 1'b1;
      // a write lands on the edge that sees waitrequest low, as the master does
      if (avs_write && !wait_r && avs_byteenable[0]) begin
         if (idx == ppcs_pkg::PPCS_IDX_EXP_CTRL) begin
            cfg_nxt.exp_port_enable_field = avs_writedata[1:0];
         end else if (idx == ppcs_pkg::PPCS_IDX_IMG_CTRL) begin
            cfg_nxt.img_port_enable_field = avs_writedata[1:0];
         end else if (idx == ppcs_pkg::PPCS_IDX_EXP_FMT) begin
            cfg_nxt.exp_vref_select_field = avs_writedata[5:4];
         end
      end
      // one wait cycle: answer comes on the second edge of the request
      if (req && wait_r) begin
         wait_nxt  = 1'b0;
         rdata_nxt = 32'h0000_0000;
         if (avs_read) begin
            if (idx == ppcs_pkg::PPCS_IDX_EXP_CTRL) begin
               rdata_nxt[1:0] = cfg_r.exp_port_enable_field;
            end else if (idx == ppcs_pkg::PPCS_IDX_IMG_CTRL) begin
               rdata_nxt[1:0] = cfg_r.img_port_enable_field;
            end else if (idx == ppcs_pkg::PPCS_IDX_EXP_FMT) begin
               rdata_nxt[5:4] = cfg_r.exp_vref_select_field;
            end else if (idx == ppcs_pkg::PPCS_IDX_STATUS) begin
               rdata_nxt[7:0] = slave_address;
               rdata_nxt[8]   = strap_r.audio_lr_clock_strap;
               rdata_nxt[9]   = sampling_r;
               rdata_nxt[10]  = tap_in_reset;
            end
         end
      end
      // the pin use and polarity bits are decoded from the field itself
      xen_use_nxt = cfg_nxt.exp_port_enable_field[1];
      xen_pol_nxt = cfg_nxt.exp_port_enable_field[0];
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_r     <= '{ppcs_pkg::PPCS_ENF_RST, ppcs_pkg::PPCS_ENF_RST,
                        ppcs_pkg::PPCS_VREF_RST};
         xen_use_r <= 1'b0;
         xen_pol_r <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         wait_r    <= 1'b1;
      end else begin
         cfg_r     <= cfg_nxt;
         xen_use_r <= xen_use_nxt;
         xen_pol_r <= xen_pol_nxt;
         rdata_r   <= rdata_nxt;
         wait_r    <= wait_nxt;
      end
   end

   // ------------------------------------------------------------
   // expansion output enable pin qualifier
   // ------------------------------------------------------------
   // field bit 1 says whether the pin counts, bit 0 picks its active level
   logic xen_hit;
   always_comb begin
      xen_hit = 1'b1;
      if (xen_use_r) begin
         xen_hit = xen_s ^ xen_pol_r;
      end
   end

   // ------------------------------------------------------------
   // pin control outputs
   // ------------------------------------------------------------
   function automatic logic port_drive(input logic [1:0] fld, input logic pin);
      case (fld)
         ppcs_pkg::PPCS_EN_FLOAT:  port_drive = 1'b0;
         ppcs_pkg::PPCS_EN_DRIVE:  port_drive = 1'b1;
         ppcs_pkg::PPCS_EN_PIN_HI: port_drive = pin;
         default:                  port_drive = ~pin;
      endcase
   endfunction

   logic [7:0] saddr_nxt;
   logic       xoe_n_nxt, ioe_n_nxt, vo_nxt, voe_n_nxt, tdo_nxt, tdo_oe_n_nxt;
   logic       tap_rst_nxt, strap_oe_n_nxt;
   logic [7:0] saddr_r;
   logic       xoe_n_r, ioe_n_r, vo_r, voe_n_r, vcap_r, tdo_r, tdo_oe_n_r, tap_rst_r;
   logic       strap_oe_n_r, rt_o_r, alr_o_r, osc_r;
   always_comb begin
      saddr_nxt = strap_r.realtime_ctrl_out_strap ? ppcs_pkg::PPCS_SLAVE_ALT
                                                  : ppcs_pkg::PPCS_SLAVE_DEFAULT;
      xoe_n_nxt = ~((cfg_r.exp_port_enable_field != ppcs_pkg::PPCS_EN_FLOAT)
                    & xen_hit);
      ioe_n_nxt = ~port_drive(cfg_r.img_port_enable_field, ien_s);
      // vref only drives while the whole expansion port drives
      voe_n_nxt = xoe_n_nxt | (cfg_r.exp_vref_select_field == ppcs_pkg::PPCS_VREF_INPUT);
      vo_nxt    = cfg_r.exp_vref_select_field[1] ? ~dec_vref : dec_vref;
      // test reset passes the synchroniser too, so it acts three edges late
      tap_rst_nxt  = ~trst_n_s;
      tdo_oe_n_nxt = ~((tap_shift_dr | tap_shift_ir) & trst_n_s);
      tdo_nxt      = tap_tdo_data;
      strap_oe_n_nxt = sampling_r;
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         saddr_r      <= ppcs_pkg::PPCS_SLAVE_DEFAULT;
         xoe_n_r      <= 1'b1;
         ioe_n_r      <= 1'b1;
         vo_r         <= 1'b0;
         voe_n_r      <= 1'b1;
         vcap_r       <= 1'b0;
         tdo_r        <= 1'b0;
         tdo_oe_n_r   <= 1'b1;
         tap_rst_r    <= 1'b1;
         strap_oe_n_r <= 1'b1;
         rt_o_r       <= 1'b0;
         alr_o_r      <= 1'b0;
         osc_r        <= 1'b0;
      end else begin
         saddr_r      <= saddr_nxt;
         xoe_n_r      <= xoe_n_nxt;
         ioe_n_r      <= ioe_n_nxt;
         vo_r         <= vo_nxt;
         voe_n_r      <= voe_n_nxt;
         vcap_r       <= vref_s;
         tdo_r        <= tdo_nxt;
         tdo_oe_n_r   <= tdo_oe_n_nxt;
         tap_rst_r    <= tap_rst_nxt;
         strap_oe_n_r <= strap_oe_n_nxt;
         rt_o_r       <= rt_func_data;
         alr_o_r      <= alr_func_data;
         osc_r        <= osc_s;
      end
   end

   assign avs_readdata               = rdata_r;
   assign avs_waitrequest            = wait_r;
   assign slave_address              = saddr_r;
   assign xtal_32m_sel               = strap_r.audio_lr_clock_strap;
   assign exp_port_oe_n              = xoe_n_r;
   assign img_port_oe_n              = ioe_n_r;
   assign exp_vertical_reference_out = vo_r;
   assign exp_vertical_reference_oe_n = voe_n_r;
   assign exp_vref_captured          = vcap_r;
   assign tap_in_reset               = tap_rst_r;
   assign test_data_out              = tdo_r;
   assign test_data_out_oe_n         = tdo_oe_n_r;
   assign realtime_ctrl_out_out      = rt_o_r;
   assign realtime_ctrl_out_oe_n     = strap_oe_n_r;
   assign audio_lr_clock_out         = alr_o_r;
   assign audio_lr_clock_oe_n        = strap_oe_n_r;
   assign aux_oscillator_output      = osc_r;

endmodule // ppcs_top

// [bench/ppcs_top_asserts.sv]
/* checker for ppcs_top: watches its ports only.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module ppcs_top_asserts (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic [7:0] slave_address,
   input wire logic       xtal_32m_sel,
   input wire logic       realtime_ctrl_out_oe_n,
   input wire logic       realtime_ctrl_out_out,
   input wire logic       rt_func_data,
   input wire logic       test_reset_n,
   input wire logic       tap_shift_dr,
   input wire logic       tap_shift_ir,
   input wire logic       tap_in_reset,
   input wire logic       test_data_out_oe_n,
   input wire logic       osc_clk_div,
   input wire logic       aux_oscillator_output
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (reset);
   a_bus_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   a_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_strap_float: assert property ($fell(reset) |-> realtime_ctrl_out_oe_n [*8])
      else $error("strap pin driven during sampling");
   a_slave_pair: assert property (slave_address == 8'h42 || slave_address == 8'h40)
      else $error("slave address outside the pair");
   a_strap_hold: assert property (
      !realtime_ctrl_out_oe_n && $past(!realtime_ctrl_out_oe_n)
      |-> $stable(slave_address) && $stable(xtal_32m_sel))
      else $error("strap result changed without reset");
   a_func_out: assert property (
      !realtime_ctrl_out_oe_n |-> realtime_ctrl_out_out == $past(rt_func_data))
      else $error("strap pin not back on its function");
   a_tap_reset: assert property (!test_reset_n [*3] |=> tap_in_reset)
      else $error("test reset not honoured");
   a_tdo_idle: assert property ((!tap_shift_dr && !tap_shift_ir) [*3] |=> test_data_out_oe_n)
      else $error("test data out driven while idle");
   a_tdo_reset: assert property (tap_in_reset [*2] |-> test_data_out_oe_n)
      else $error("test data out driven in test reset");
   a_aux_osc: assert property (
      $stable(osc_clk_div) [*3] |=> aux_oscillator_output == $past(osc_clk_div))
      else $error("aux output does not follow oscillator");
   c_alt_addr: cover property (!realtime_ctrl_out_oe_n && slave_address == 8'h40);
   c_tdo_on: cover property (!test_data_out_oe_n);
   c_read: cover property (avs_read && !avs_waitrequest);
endmodule // ppcs_top_asserts

bind ppcs_top ppcs_top_asserts u_ppcs_top_asserts (.clk(clk), .reset(reset),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .slave_address(slave_address), .xtal_32m_sel(xtal_32m_sel),
   .realtime_ctrl_out_oe_n(realtime_ctrl_out_oe_n),
   .realtime_ctrl_out_out(realtime_ctrl_out_out), .rt_func_data(rt_func_data),
   .test_reset_n(test_reset_n), .tap_shift_dr(tap_shift_dr), .tap_shift_ir(tap_shift_ir),
   .tap_in_reset(tap_in_reset), .test_data_out_oe_n(test_data_out_oe_n),
   .osc_clk_div(osc_clk_div), .aux_oscillator_output(aux_oscillator_output));

// [bench/ppcs_board_model.sv]
/* board side of the strap pins: optional pull-up resistors.
   assumes the pad pull-down wins when no resistor is fitted. */
`timescale 1ns/100ps
module ppcs_board_model (
   input wire logic rt_strap,
   input wire logic alr_strap,
   input wire logic rt_out,
   input wire logic rt_oe_n,
   input wire logic alr_out,
   input wire logic alr_oe_n,
   output logic     rt_pin,
   output logic     alr_pin
);
   // floating pin shows the resistor or pull-down level, a driven pin shows the output
   assign rt_pin = rt_oe_n ? rt_strap : rt_out;
   assign alr_pin = alr_oe_n ? alr_strap : alr_out;
endmodule // ppcs_board_model

// [bench/port_pin_config_and_straps_tb.sv]
/* bench for the pin config block: straps, port enables, tap, oscillator.
   assumes ppcs_pkg, ppcs_top, the checker and the board model compiled first. */
`timescale 1ns/100ps
module port_pin_config_and_straps_tb;
   logic clk, reset, avs_read, avs_write, avs_waitrequest, rt_strap, alr_strap;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   logic realtime_ctrl_out_in, realtime_ctrl_out_out, realtime_ctrl_out_oe_n;
   logic audio_lr_clock_in, audio_lr_clock_out, audio_lr_clock_oe_n, rt_func_data;
   logic alr_func_data, xtal_32m_sel, exp_port_output_enable_pin, img_port_output_enable_pin;
   logic [7:0] slave_address;
   logic exp_port_oe_n, img_port_oe_n, exp_vertical_reference_in, dec_vref;
   logic exp_vertical_reference_out, exp_vertical_reference_oe_n, exp_vref_captured;
   logic test_reset_n, tap_shift_dr, tap_shift_ir, tap_tdo_data, tap_in_reset;
   logic test_data_out, test_data_out_oe_n, osc_clk_div, aux_oscillator_output;
   ppcs_pkg::ppcs_cfg_t cfg;
   integer seed, errors, total_checks;

   ppcs_top u_ppcs_top (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .realtime_ctrl_out_in,
      .realtime_ctrl_out_out, .realtime_ctrl_out_oe_n, .audio_lr_clock_in, .audio_lr_clock_out,
      .audio_lr_clock_oe_n, .rt_func_data, .alr_func_data, .slave_address, .xtal_32m_sel,
      .exp_port_output_enable_pin, .img_port_output_enable_pin, .exp_port_oe_n, .img_port_oe_n,
      .exp_vertical_reference_in, .dec_vref, .exp_vertical_reference_out,
      .exp_vertical_reference_oe_n, .exp_vref_captured, .test_reset_n, .tap_shift_dr,
      .tap_shift_ir, .tap_tdo_data, .tap_in_reset, .test_data_out, .test_data_out_oe_n,
      .osc_clk_div, .aux_oscillator_output);
   ppcs_board_model u_ppcs_board_model (.rt_strap, .alr_strap, .rt_out(realtime_ctrl_out_out),
      .rt_oe_n(realtime_ctrl_out_oe_n), .alr_out(audio_lr_clock_out),
      .alr_oe_n(audio_lr_clock_oe_n), .rt_pin(realtime_ctrl_out_in),
      .alr_pin(audio_lr_clock_in));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // shared tasks and expectations
   // ------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // request held until a rising edge samples waitrequest low; data taken there
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= wd;
      {avs_write, avs_read} <= {wr, !wr};
      n = 0;
      do begin
         @(posedge clk);
         rd = avs_readdata;
         n++;
         if (n > 50) begin
            errors++;
            summarize();
         end
      end while (avs_waitrequest !== 1'b0);
      {avs_write, avs_read} <= 2'h0;
   endtask
   function automatic logic en_oe(input logic [1:0] f, input logic pin);
      case (f)
         2'h0: return 1'b1;
         2'h1: return 1'b0;
         2'h2: return !pin;
         default: return pin;
      endcase
   endfunction
   task automatic straps(input logic s, input logic [7:0] adr);
      int n;
      {rt_strap, alr_strap} <= {s, s};
      reset <= 1'b1;
      cyc(5);
      chk("slave_rst", slave_address, 8'h42);
      reset <= 1'b0;
      cyc(3);
      chk("strap_oe", {realtime_ctrl_out_oe_n, audio_lr_clock_oe_n}, 2'h3);
      n = 0;
      while (realtime_ctrl_out_oe_n !== 1'b0 && n < 400) begin
         cyc(1);
         n++;
      end
      chk("strap_wait", n < 400, 1'b1);
      if (n >= 400) summarize();
      chk("slave", slave_address, adr);
      chk("xtal", xtal_32m_sel, s);
      bus(1'b0, ppcs_pkg::PPCS_IDX_STATUS, 32'h0);
      chk("status", rd, {21'h0, 2'h0, s, adr});
      {rt_strap, alr_strap} <= {!s, !s};
      {rt_func_data, alr_func_data} <= 2'h3;
      cyc(4);
      chk("slave_hold", slave_address, adr);
      chk("xtal_hold", xtal_32m_sel, s);
      chk("rt_out", realtime_ctrl_out_out, 1'b1);
      chk("alr_out", {audio_lr_clock_oe_n, audio_lr_clock_out}, 2'h1);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 32'h60dad1ed;
      errors = 0;
      total_checks = 0;
      {reset, test_reset_n, avs_byteenable} = 6'h31;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {rt_strap, alr_strap, rt_func_data, alr_func_data, exp_port_output_enable_pin,
         img_port_output_enable_pin, exp_vertical_reference_in, dec_vref, tap_shift_dr,
         tap_shift_ir, tap_tdo_data, osc_clk_div} = '0;
      straps(1'b0, 8'h42);
      straps(1'b1, 8'h40);
      // all codes of both fields first, random mixes after
      for (int k = 0; k < 24; k++) begin
         cfg = (k < 16) ? {k[1:0], k[3:2], k[1:0] ^ k[3:2]} : 6'($random(seed));
         {exp_port_output_enable_pin, img_port_output_enable_pin, dec_vref,
            exp_vertical_reference_in, rt_func_data, alr_func_data} <= 6'($random(seed));
         bus(1'b1, ppcs_pkg::PPCS_IDX_EXP_CTRL, {30'h0, cfg.exp_port_enable_field});
         bus(1'b1, ppcs_pkg::PPCS_IDX_IMG_CTRL, {30'h0, cfg.img_port_enable_field});
         bus(1'b1, ppcs_pkg::PPCS_IDX_EXP_FMT, {26'h0, cfg.exp_vref_select_field, 4'h0});
         cyc(4);
         chk("exp_oe", exp_port_oe_n, en_oe(cfg.exp_port_enable_field,
            exp_port_output_enable_pin));
         chk("img_oe", img_port_oe_n, en_oe(cfg.img_port_enable_field,
            img_port_output_enable_pin));
         chk("vref_oe", exp_vertical_reference_oe_n, cfg.exp_vref_select_field == 2'h0
            || en_oe(cfg.exp_port_enable_field, exp_port_output_enable_pin));
         chk("vref_in", exp_vref_captured, exp_vertical_reference_in);
         if (cfg.exp_vref_select_field inside {2'h1, 2'h2})
            chk("vref_out", exp_vertical_reference_out,
               dec_vref ^ cfg.exp_vref_select_field[1]);
         bus(1'b0, ppcs_pkg::PPCS_IDX_EXP_CTRL, 32'h0);
         chk("exp_rd", rd[1:0], cfg.exp_port_enable_field);
      end
      bus(1'b1, 8'h10, 32'hFF);
      bus(1'b0, 8'h10, 32'h0);
      chk("unmapped", rd, 32'h0);
      {tap_shift_dr, tap_tdo_data, test_reset_n} <= 3'h6;
      cyc(4);
      chk("tap_rst", tap_in_reset, 1'b1);
      chk("tdo_oe_rst", test_data_out_oe_n, 1'b1);
      test_reset_n <= 1'b1;
      cyc(4);
      chk("tdo_oe", {tap_in_reset, test_data_out_oe_n, test_data_out}, 3'h1);
      {tap_shift_dr, tap_shift_ir} <= 2'h1;
      cyc(4);
      chk("tdo_ir", test_data_out_oe_n, 1'b0);
      tap_shift_ir <= 1'b0;
      cyc(4);
      chk("tdo_idle", test_data_out_oe_n, 1'b1);
      for (int k = 0; k < 6; k++) begin
         osc_clk_div <= 1'($random(seed));
         cyc(4);
         chk("aux_osc", aux_oscillator_output, osc_clk_div);
      end
      summarize();
   end
endmodule // port_pin_config_and_straps_tb
